// file: tb_top.sv
// Purpose: Self-checking bench for the two-stage sinc decimator.
// Assumes: Steady or zero-mean streams, so settled words have exact values.
// Notes:   The longest ratios are only shown to stay silent; a full word
//          there would take far too many cycles.
`timescale 1ns/1ps
`include "tsd_defs.svh"
module tb_top;
    import tsd_pkg::*;
    logic      core_clk          = 1'b0;
    logic      nrst              = 1'b0;
    tsd_rate_t rateSelect        = 3'h7;
    logic      secondOrderSelect = 1'b0;
    logic      patSel            = 1'b0;
    logic      modBit;
    logic      resultValid;
    tsd_out_t  resultData;
    logic      resultSettled;
    integer    fails             = 0;
    integer    numChecks         = 0;
    integer    seed              = 32'h55C5;
    integer    quiet;

    // Clock of 4 ns period.
    always #2 core_clk = ~core_clk;

    tsd_mod_model model (.core_clk(core_clk), .nrst(nrst), .patSel(patSel), .modBit(modBit));

    tsd_decimator dut
    (
        .core_clk          (core_clk),
        .nrst              (nrst),
        .rateSelect        (rateSelect),
        .secondOrderSelect (secondOrderSelect),
        .modBit            (modBit),
        .resultValid       (resultValid),
        .resultData        (resultData),
        .resultSettled     (resultSettled)
    );

    // Verdict and end of run.
    task automatic finishTest;
        if (fails == 0 && numChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // One comparison, reported at once on mismatch.
    task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
        numChecks = numChecks + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // New settings, then nWords results checked for spacing, value and settling.
    // Early words are skipped for value, as the fifth-order stage is still filling.
    task automatic runCase(input logic [2:0] code, input logic ord, input integer rat,
                           input integer nWords);
        integer      k;
        integer      gap;
        integer      t;
        longint      expV;
        longint      hist [$];
        logic [31:0] rnd;
        rnd = $random(seed);
        @(posedge core_clk);
        rateSelect        <= code;
        secondOrderSelect <= ord;
        patSel            <= (code == `TSD_SEL_1) ? rnd[0] : 1'b0;
        if (code != `TSD_SEL_1)
            rnd[0] = 1'b0;
        k   = 0;
        gap = 0;
        t   = 0;
        while (k < nWords)
        begin
            @(posedge core_clk);
            #1;
            t   = t + 1;
            gap = gap + 1;
            if (t > 1100 * rat * (nWords + 1) + 2000)
            begin
                fails = fails + 1;
                finishTest();
            end
            if (resultValid === 1'b1)
            begin
                // Model: one settled R-sum per word; second_order_select pairs it with the one before.
                hist.push_back(rnd[0] ? 0 : -longint'(rat) * (longint'(1) << 30));
                expV = (ord && hist.size() > 1) ? hist[$] + hist[$ - 1] : hist[$];
                if (k > 0)
                    check("spacing", 64'(512 * rat), 64'(gap));
                if ((ord ? (k - 1) * rat : k * rat) >= 6 && !(ord && k == 0))
                    check("data", 64'(expV), resultData);
                check("settled", 64'(!(ord && k == 0)), 64'(resultSettled));
                gap = 0;
                k   = k + 1;
            end
        end
    endtask

    // Main sequence: both orders at ratios 1 and 4, first order only at 12 and 36, then silence at the long ones.
    initial
    begin
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        runCase(`TSD_SEL_1, 1'b0, `TSD_RATE_1, 8);
        runCase(`TSD_SEL_1, 1'b1, `TSD_RATE_1, 8);
        runCase(`TSD_SEL_4, 1'b0, `TSD_RATE_4, 4);
        runCase(`TSD_SEL_4, 1'b1, `TSD_RATE_4, 4);
        runCase(`TSD_SEL_12, 1'b0, `TSD_RATE_12, 3);
        runCase(`TSD_SEL_36, 1'b0, `TSD_RATE_36, 1);
        // Codes 000 to 011 are the four slowest rates; none may give a word this soon.
        quiet = 0;
        for (int c = 0; c < 4; c++)
        begin
            @(posedge core_clk);
            rateSelect <= 3'(c);
            repeat (5000)
            begin
                @(posedge core_clk);
                #1;
                if (resultValid === 1'b1)
                    quiet = quiet + 1;
            end
        end
        check("silent", 64'h0, 64'(quiet));
        finishTest();
    end
endmodule

// file: tsd_decimator.sv
// Purpose: Two-stage decimating low-pass filter for a one-bit stream.
// Assumes: Modulator bit is synchronous and sampled every eighth clock.
// Notes:   Second_order_select sums two adjacent boxcars, one flat window of 2R words; output is raw, not normalised.
`timescale 1ns/1ps
`include "tsd_defs.svh"
module tsd_decimator
(
    // Clock and reset
    input  wire logic             core_clk,
    input  wire logic             nrst,
    // Settings
    input  wire tsd_pkg::tsd_rate_t rateSelect,
    input  wire logic             secondOrderSelect,
    // Modulator stream
    input  wire logic             modBit,
    // Result
    output logic                  resultValid,
    output tsd_pkg::tsd_out_t     resultData,
    output logic                  resultSettled
);
    import tsd_pkg::*;
    tsd_s1_if   s1 ();
    tsd_rate_t  rate_q;
    logic       order_q;
    logic       change;
    logic [10:0] ratio;
    logic [10:0] cnt_q;
    tsd_out_t    acc1_q;
    tsd_out_t    sum2;
    logic [20:0] period;
    logic [20:0] gapCnt_q;
    logic        armed_q;
    tsd_out_t    box1_q;
    tsd_out_t    sum1;
    logic [1:0]  settle_q;
    logic        valid_q;
    tsd_out_t    data_q;
    logic        settled_q;
    logic        lastIn;

    // A settings change restarts both stages so no stale average leaks out.
    assign change = (rateSelect != rate_q) || (secondOrderSelect != order_q);
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rate_q  <= `TSD_SEL_1440;
            order_q <= 1'b0;
        end
        else
        begin
            rate_q  <= rateSelect;
            order_q <= secondOrderSelect;
        end
    end

    tsd_sinc5 u_sinc5
    (
        .core_clk (core_clk),
        .nrst     (nrst),
        .modBit   (modBit),
        .clear    (change),
        .res      (s1)
    );

    // Ratio lookup from the rate field.
    always_comb
    begin
        unique case (rate_q)
            `TSD_SEL_1:    ratio = `TSD_RATE_1;
            `TSD_SEL_4:    ratio = `TSD_RATE_4;
            `TSD_SEL_12:   ratio = `TSD_RATE_12;
            `TSD_SEL_36:   ratio = `TSD_RATE_36;
            `TSD_SEL_240:  ratio = `TSD_RATE_240;
            `TSD_SEL_288:  ratio = `TSD_RATE_288;
            `TSD_SEL_864:  ratio = `TSD_RATE_864;
            `TSD_SEL_1440: ratio = `TSD_RATE_1440;
        endcase
    end

    assign lastIn = s1.valid && (cnt_q == ratio - 11'd1);
    assign sum1   = acc1_q + {{33{s1.data[30]}}, s1.data};

    // Input counter; the same count closes both orders, so rates match.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            cnt_q <= 11'h000;
        else if (change)
            cnt_q <= 11'h000;
        else if (lastIn)
            cnt_q <= 11'h000;
        else if (s1.valid)
            cnt_q <= cnt_q + 11'h001;
    end

    // First boxcar accumulates every first-stage word over R inputs.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc1_q <= '0;
            box1_q <= '0;
        end
        else if (change)
        begin
            acc1_q <= '0;
            box1_q <= '0;
        end
        else if (lastIn)
        begin
            acc1_q <= '0;
            box1_q <= sum1;
        end
        else if (s1.valid)
            acc1_q <= sum1;
    end

    // Second_order_select adds the previous boxcar, a flat window of 2R taps. Kept
    // combinational so the word lands one clock after its closing input.
    assign sum2 = order_q ? (sum1 + box1_q) : sum1;

    // Settling counter: one word for sinc1, two for second_order_select after restart.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            settle_q <= 2'h0;
        else if (change)
            settle_q <= 2'h0;
        else if (lastIn && settle_q != 2'h2)
            settle_q <= settle_q + 2'h1;
    end

    // Output registers; the strobe is a single clock wide.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            valid_q   <= 1'b0;
            data_q    <= '0;
            settled_q <= 1'b0;
        end
        else
        begin
            valid_q <= lastIn && !change;
            if (lastIn && !change)
            begin
                data_q    <= sum2;
                settled_q <= order_q ? (settle_q != 2'h0) : 1'b1;
            end
            else if (change)
                settled_q <= 1'b0;
        end
    end
    assign resultValid   = valid_q;
    assign resultData    = data_q;
    assign resultSettled = settled_q;

    // Checker helper: clocks since the last word. It arms only once a word has
    // come out after a restart, so a restart never trips the spacing check.
    assign period = 21'(ratio) * 21'(`TSD_S1_PERIOD);
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gapCnt_q <= 21'h00000;
            armed_q  <= 1'b0;
        end
        else if (change)
        begin
            gapCnt_q <= 21'h00000;
            armed_q  <= 1'b0;
        end
        else if (resultValid)
        begin
            gapCnt_q <= 21'h00001;
            armed_q  <= 1'b1;
        end
        else if (armed_q)
            gapCnt_q <= gapCnt_q + 21'h00001;
    end

    // Strobe follows a closing input by exactly one clock.
    sequence sClose;
        lastIn && !change;
    endsequence
    AST_VALID_AFTER_CLOSE: assert property (@(posedge core_clk) disable iff (!nrst)
        sClose |=> resultValid)
        else $error("Result strobe missing after closing input.");
    AST_VALID_ONE_CYCLE: assert property (@(posedge core_clk) disable iff (!nrst)
        resultValid |=> !resultValid)
        else $error("Result strobe wider than one clock.");
    AST_RATIO_1440: assert property (@(posedge core_clk) disable iff (!nrst)
        (rate_q == `TSD_SEL_1440) |-> (ratio == 11'd1440))
        else $error("Wrong ratio for slowest rate.");
    AST_RATIO_4: assert property (@(posedge core_clk) disable iff (!nrst)
        (rate_q == `TSD_SEL_4) |-> (ratio == 11'd4))
        else $error("Wrong ratio for rate four.");
    AST_SINC1_SETTLED: assert property (@(posedge core_clk) disable iff (!nrst)
        (sClose and !order_q) |=> resultSettled)
        else $error("Sinc1 word not flagged settled.");
    AST_SECOND_ORDER_SELECT_FIRST: assert property (@(posedge core_clk) disable iff (!nrst)
        (sClose and order_q and settle_q == 2'h0) |=> !resultSettled)
        else $error("Second_order_select first word flagged settled.");
    AST_CHANGE_CLEARS: assert property (@(posedge core_clk) disable iff (!nrst)
        change |=> (cnt_q == 11'h000 && acc1_q == '0))
        else $error("Accumulators not cleared on setting change.");
    AST_RATE1_EVERY: assert property (@(posedge core_clk) disable iff (!nrst)
        (s1.valid && rate_q == `TSD_SEL_1 && !change) |=> resultValid)
        else $error("Ratio one must pass every first-stage word.");
    AST_SINC1_DATA: assert property (@(posedge core_clk) disable iff (!nrst)
        (sClose and !order_q) |=> (resultData == $past(sum1)))
        else $error("Sinc1 output is not the boxcar sum.");
    AST_OUT_SPACING: assert property (@(posedge core_clk) disable iff (!nrst)
        (resultValid && armed_q) |-> (gapCnt_q == period))
        else $error("Result words not spaced by the selected ratio.");
    AST_NO_WORD_ON_CHANGE: assert property (@(posedge core_clk) disable iff (!nrst)
        change |=> !resultValid)
        else $error("Result strobe raised after a restart.");
    AST_CHANGE_UNSETTLES: assert property (@(posedge core_clk) disable iff (!nrst)
        change |=> !resultSettled)
        else $error("Settled flag kept across a restart.");
    AST_SECOND_ORDER_SELECT_LATER: assert property (@(posedge core_clk) disable iff (!nrst)
        (sClose and order_q and settle_q != 2'h0) |=> resultSettled)
        else $error("Second_order_select second word not flagged settled.");
endmodule

// file: tsd_defs.svh
// Purpose: Constants for the two-stage sinc decimator.
// Assumes: Core clock stands in for the converter clock.
// Notes:   Definitions only.
`ifndef TSD_DEFS_SVH
`define TSD_DEFS_SVH
`define TSD_MOD_DIV      10'd8
`define TSD_S1_RATIO     10'd64
`define TSD_TICK_LAST    (`TSD_MOD_DIV - 10'd1)
`define TSD_S1_PERIOD    (`TSD_MOD_DIV * `TSD_S1_RATIO)
`define TSD_S1_LAST      (`TSD_MOD_DIV * `TSD_S1_RATIO - 10'd1)
`define TSD_RATE_1       11'd1
`define TSD_RATE_4       11'd4
`define TSD_RATE_12      11'd12
`define TSD_RATE_36      11'd36
`define TSD_RATE_240     11'd240
`define TSD_RATE_288     11'd288
`define TSD_RATE_864     11'd864
`define TSD_RATE_1440    11'd1440
`define TSD_SEL_1        3'h7
`define TSD_SEL_4        3'h6
`define TSD_SEL_12       3'h5
`define TSD_SEL_36       3'h4
`define TSD_SEL_240      3'h3
`define TSD_SEL_288      3'h2
`define TSD_SEL_864      3'h1
`define TSD_SEL_1440     3'h0
`endif

// file: tsd_mod_model.sv
// Purpose: Behavioural one-bit modulator stream feeding the decimator.
// Assumes: The decimator samples once per eight clocks.
// Notes:   Pattern 0 is a steady minus one, pattern 1 alternates every bit.
`timescale 1ns/1ps
module tsd_mod_model
(
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // Pattern choice
    input  wire logic patSel,
    // Stream
    output logic      modBit
);
    logic [2:0] div_q;

    // One fresh bit per eight clocks, so every design sample sees a new bit.
    // The change lands by non-blocking update, so sampling never races it.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            div_q  <= 3'h0;
            modBit <= 1'b0;
        end
        else
        begin
            div_q <= div_q + 3'h1;
            if (div_q == 3'h7)
                modBit <= patSel ? ~modBit : 1'b0;
        end
    end
endmodule

// file: tsd_pkg.sv
// Purpose: Types for the two-stage sinc decimator.
// Assumes: Nothing beyond the defines header.
// Notes:   Result widths are fixed by the filter growth.
package tsd_pkg;
    typedef logic [2:0]  tsd_rate_t;
    typedef logic [30:0] tsd_s1_t;
    typedef logic [63:0] tsd_out_t;
endpackage

// file: tsd_s1_if.sv
// Purpose: Carries first-stage results to the second stage.
// Assumes: One clock domain.
// Notes:   Valid is a one-cycle strobe.
`timescale 1ns/1ps
interface tsd_s1_if;
    import tsd_pkg::*;
    logic    valid;
    tsd_s1_t data;
    modport src (output valid, output data);
    modport dst (input valid, input data);
endinterface

// file: tsd_sinc5.sv
// Purpose: Fixed fifth-order sinc decimator, ratio 64.
// Assumes: A modulator sample is offered once every eight clocks.
// Notes:   Cascaded integrators and combs wrap modulo 2^31 on purpose.
`timescale 1ns/1ps
`include "tsd_defs.svh"
module tsd_sinc5
(
    // Clock and reset
    input  wire logic   core_clk,
    input  wire logic   nrst,
    // Modulator side
    input  wire logic   modBit,
    input  wire logic   clear,
    // Result side
    tsd_s1_if.src       res
);
    import tsd_pkg::*;
    tsd_s1_t  integ_q [5];
    tsd_s1_t  combZ_q [5];
    tsd_s1_t  combIn  [6];
    logic [9:0] phase_q;
    logic       tick;
    logic       valid_q;
    tsd_s1_t    data_q;

    // Phase counter marks modulator ticks (clk/8) and decimation (clk/512).
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
            phase_q <= 10'h000;
        else if (clear)
            phase_q <= 10'h000;
        else if (phase_q == `TSD_S1_LAST)
            phase_q <= 10'h000;
        else
            phase_q <= phase_q + 10'h001;
    end
    assign tick = ((phase_q & `TSD_TICK_LAST) == `TSD_TICK_LAST);

    // Integrators run at the modulator rate; bit maps to +1 or -1.
    genvar i;
    generate
        for (i = 0; i < 5; i++)
        begin : g_int
            // Stage zero takes the bit; the split keeps stage zero from naming a
            // neighbour below the array.
            if (i == 0)
            begin : g_first
                always_ff @(posedge core_clk or negedge nrst)
                begin
                    if (!nrst)
                        integ_q[i] <= '0;
                    else if (clear)
                        integ_q[i] <= '0;
                    else if (tick)
                        integ_q[i] <= integ_q[i] + (modBit ? 31'h00000001
                                                           : 31'h7FFFFFFF);
                end
            end
            else
            begin : g_next
                always_ff @(posedge core_clk or negedge nrst)
                begin
                    if (!nrst)
                        integ_q[i] <= '0;
                    else if (clear)
                        integ_q[i] <= '0;
                    else if (tick)
                        integ_q[i] <= integ_q[i] + integ_q[i-1];
                end
            end
            assign combIn[i+1] = combIn[i] - combZ_q[i];
            always_ff @(posedge core_clk or negedge nrst)
            begin
                if (!nrst)
                    combZ_q[i] <= '0;
                else if (clear)
                    combZ_q[i] <= '0;
                else if (phase_q == `TSD_S1_LAST)
                    combZ_q[i] <= combIn[i];
            end
        end
    endgenerate
    assign combIn[0] = integ_q[4];

    // Comb chain runs once per 64 modulator samples.
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            valid_q <= 1'b0;
            data_q  <= '0;
        end
        else
        begin
            valid_q <= !clear && (phase_q == `TSD_S1_LAST);
            if (!clear && phase_q == `TSD_S1_LAST)
                data_q <= combIn[5];
        end
    end
    assign res.valid = valid_q;
    assign res.data  = data_q;

    // No second result comes within the 8 clocks after each one.
    property pS1Spacing;
        @(posedge core_clk) disable iff (!nrst)
        (res.valid && !clear) |=> !res.valid [*8];
    endproperty
    AST_S1_SPACING: assert property (pS1Spacing)
        else $error("First stage strobe repeated too soon.");

    // A word only ever follows the phase wrap, which pins the 512-clock spacing.
    AST_S1_PHASE: assert property (@(posedge core_clk) disable iff (!nrst)
        (res.valid && !clear) |-> (phase_q == 10'h000))
        else $error("First stage strobe off its phase.");
endmodule
